// ==== core/mpc_pkg.sv ====
`default_nettype none
package mpc_pkg;
   // ------------------------------------------------------------
   // register indices; byte address is four times the index
   // ------------------------------------------------------------
   localparam logic [11:0] IDX_MAIN = 12'h0f20;
   localparam logic [11:0] IDX_AUX = 12'h0f21;
   localparam logic [11:0] IDX_DEAD = 12'h0f22;
   localparam logic [11:0] IDX_PERIOD = 12'h0f30;
   localparam logic [11:0] IDX_DUTY0 = 12'h0f31;
   localparam logic [11:0] IDX_OUTDIS = 12'h0f37;
   localparam logic [11:0] IDX_CFG = 12'h0f38;
   localparam logic [11:0] IDX_STATUS = 12'h0f39;
   localparam int NCH = 6;
   // ------------------------------------------------------------
   // reset values
   // ------------------------------------------------------------
   localparam logic [7:0] MAIN_RST = 8'h00;
   localparam logic [7:0] AUX_RST = 8'h00;
   localparam logic [7:0] DEAD_RST = 8'h01;
   localparam logic [15:0] PERIOD_RST = 16'hffff;
   localparam logic [15:0] DUTY_RST = 16'h0000;
   typedef struct packed {
      logic outputs_off_ctl;
      logic selective_disable_ctl;
      logic align_center;
      logic rsv4;
      logic converter_trigger_enable;
      logic rsv2;
      logic values_ready;
      logic modulator_enable;
   } mpc_main_t;
   typedef struct packed {
      logic [1:0] reload_rate;
      logic independent_channels;
      logic pair2_invert;
      logic pair1_invert;
      logic pair0_invert;
      logic [1:0] prescale;
   } mpc_aux_t;
endpackage
`default_nettype wire

// ==== core/mpc_regs.sv ====
// Register access over APB is this design's own decision.
`default_nettype none
module mpc_regs (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [15:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic external_pwm_clock_in,
   output logic [5:0] pwm_out,
   output logic pwm_oe_n,
   output logic adc_trig
);
   // ------------------------------------------------------------
   // register file
   // ------------------------------------------------------------
   mpc_pkg::mpc_main_t main_r;
   mpc_pkg::mpc_aux_t aux_r;
   logic [7:0] dead_r;
   logic [15:0] period_hold_r;
   logic [15:0] duty_hold_r [mpc_pkg::NCH];
   logic [5:0] outdis_r;
   logic clk_ext_r;
   logic [1:0] pres_work_r;
   logic [1:0] rate_work_r;
   logic [15:0] period_work_r;
   logic [15:0] duty_work_r [mpc_pkg::NCH];
   logic [15:0] cnt_r;
   logic dir_down_r;
   logic mod_active_r;
   logic [2:0] pre_cnt_r;
   logic [2:0] rl_cnt_r;
   logic [2:0] sync_r;
   logic ext_lvl_r;
   logic [5:0] raw_prev_r;
   logic [7:0] dt_cnt_r [3];
   logic [31:0] prdata_r;
   logic pslverr_r;
   logic [5:0] pwm_out_r;
   logic adc_trig_r;

   logic wr_en;
   logic [11:0] widx;
   logic [31:0] rd_mux;
   logic rd_hit;
   logic ext_rise;
   logic pwm_tick;
   logic [2:0] pre_mask;
   logic [2:0] rl_mask;
   logic [15:0] per_m1;
   logic period_end;
   logic reload_evt;
   logic [5:0] raw;
   logic [5:0] logic_out;
   logic [5:0] force_off;
   logic [5:0] off_pat;
   logic [5:0] out_nxt;
   logic [2:0] inv;
   logic [2:0] blank;

   assign widx = paddr[13:2];
   assign wr_en = psel && penable && pwrite && (paddr[15:14] == 2'b00) && (paddr[1:0] == 2'b00);
   assign pready = 1'b1;
   assign prdata = prdata_r;
   assign pslverr = pslverr_r;
   assign pwm_out = pwm_out_r;
   assign pwm_oe_n = ~main_r.modulator_enable;
   assign adc_trig = adc_trig_r;
   assign inv = {aux_r.pair2_invert, aux_r.pair1_invert, aux_r.pair0_invert};

   // ------------------------------------------------------------
   // apb read path; data latched in the setup phase
   // ------------------------------------------------------------
   always_comb begin
      rd_mux = 32'h0000_0000;
      rd_hit = (paddr[15:14] == 2'b00) && (paddr[1:0] == 2'b00);
      if (widx == mpc_pkg::IDX_MAIN) begin
         rd_mux[7:0] = main_r;
      end else if (widx == mpc_pkg::IDX_AUX) begin
         rd_mux[7:0] = aux_r;
      end else if (widx == mpc_pkg::IDX_DEAD) begin
         rd_mux[7:0] = dead_r;
      end else if (widx == mpc_pkg::IDX_PERIOD) begin
         rd_mux[15:0] = period_hold_r;
      end else if (widx >= mpc_pkg::IDX_DUTY0 && widx < mpc_pkg::IDX_OUTDIS) begin
         rd_mux[15:0] = duty_hold_r[widx[2:0] - 3'h1];
      end else if (widx == mpc_pkg::IDX_OUTDIS) begin
         rd_mux[5:0] = outdis_r;
      end else if (widx == mpc_pkg::IDX_CFG) begin
         rd_mux[0] = clk_ext_r;
      end else if (widx == mpc_pkg::IDX_STATUS) begin
         rd_mux = {14'h0000, mod_active_r, dir_down_r, cnt_r};
      end else begin
         rd_hit = 1'b0;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata_r <= 32'h0000_0000;
         pslverr_r <= 1'b0;
      end else if (psel && !penable) begin
         prdata_r <= rd_mux;
         pslverr_r <= !rd_hit;
      end
   end

   // ------------------------------------------------------------
   // software writes
   // ------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         main_r <= mpc_pkg::MAIN_RST;
      end else if (wr_en && widx == mpc_pkg::IDX_MAIN) begin
         main_r <= pwdata[7:0];
      end else if (reload_evt && main_r.values_ready) begin
         // transfer done; a same-cycle write above wins
         main_r.values_ready <= 1'b0;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         aux_r <= mpc_pkg::AUX_RST;
      end else if (wr_en && widx == mpc_pkg::IDX_AUX) begin
         aux_r[7:6] <= pwdata[7:6];
         aux_r[4:0] <= pwdata[4:0];
         if (!main_r.modulator_enable) begin
            aux_r.independent_channels <= pwdata[5];
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         dead_r <= mpc_pkg::DEAD_RST;
      end else if (wr_en && widx == mpc_pkg::IDX_DEAD && !main_r.modulator_enable) begin
         dead_r <= pwdata[7:0];
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         period_hold_r <= mpc_pkg::PERIOD_RST;
         outdis_r <= 6'h00;
         clk_ext_r <= 1'b0;
         for (int i = 0; i < mpc_pkg::NCH; i++) begin
            duty_hold_r[i] <= mpc_pkg::DUTY_RST;
         end
      end else if (wr_en) begin
         if (widx == mpc_pkg::IDX_PERIOD) begin
            period_hold_r <= pwdata[15:0];
         end else if (widx >= mpc_pkg::IDX_DUTY0 && widx < mpc_pkg::IDX_OUTDIS) begin
            duty_hold_r[widx[2:0] - 3'h1] <= pwdata[15:0];
         end else if (widx == mpc_pkg::IDX_OUTDIS) begin
            outdis_r <= pwdata[5:0];
         end else if (widx == mpc_pkg::IDX_CFG) begin
            clk_ext_r <= pwdata[0];
         end
      end
   end

   // ------------------------------------------------------------
   // clock source and prescaler
   // ------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sync_r <= 3'h0;
         ext_lvl_r <= 1'b0;
      end else begin
         sync_r <= {sync_r[1:0], external_pwm_clock_in};
         if (sync_r[1] == sync_r[2]) begin
            ext_lvl_r <= sync_r[2];
         end
      end
   end

   // a level counts only once stages two and three agree
   assign ext_rise = (sync_r[1] == sync_r[2]) && sync_r[2] && !ext_lvl_r;

   always_comb begin
      case (pres_work_r)
         2'b00: pre_mask = 3'h0;
         2'b01: pre_mask = 3'h1;
         2'b10: pre_mask = 3'h3;
         default: pre_mask = 3'h7;
      endcase
   end

   assign pwm_tick = (!clk_ext_r || ext_rise) && ((pre_cnt_r & pre_mask) == pre_mask);

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pre_cnt_r <= 3'h0;
      end else if (!main_r.modulator_enable) begin
         pre_cnt_r <= 3'h0;
      end else if (!clk_ext_r || ext_rise) begin
         pre_cnt_r <= pwm_tick ? 3'h0 : pre_cnt_r + 3'h1;
      end
   end

   // ------------------------------------------------------------
   // master counter
   // ------------------------------------------------------------
   assign per_m1 = (period_work_r == 16'h0000) ? 16'h0000 : period_work_r - 16'h0001;
   // centre mode: period ends at the bottom turn of the triangle
   assign period_end = main_r.modulator_enable && pwm_tick &&
                       (main_r.align_center ? (dir_down_r && cnt_r == 16'h0000) : (cnt_r >= per_m1));

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cnt_r <= 16'h0000;
         dir_down_r <= 1'b0;
      end else if (!main_r.modulator_enable) begin
         cnt_r <= 16'h0000;
         dir_down_r <= 1'b0;
      end else if (pwm_tick) begin
         if (!main_r.align_center) begin
            cnt_r <= (cnt_r >= per_m1) ? 16'h0000 : cnt_r + 16'h0001;
            dir_down_r <= 1'b0;
         end else if (dir_down_r) begin
            if (cnt_r == 16'h0000) begin
               dir_down_r <= 1'b0;
            end else begin
               cnt_r <= cnt_r - 16'h0001;
            end
         end else if (cnt_r >= per_m1) begin
            dir_down_r <= 1'b1;
         end else begin
            cnt_r <= cnt_r + 16'h0001;
         end
      end
   end

   // ------------------------------------------------------------
   // reload scheduling and working registers
   // ------------------------------------------------------------
   always_comb begin
      case (rate_work_r)
         2'b00: rl_mask = 3'h0;
         2'b01: rl_mask = 3'h1;
         2'b10: rl_mask = 3'h3;
         default: rl_mask = 3'h7;
      endcase
   end

   assign reload_evt = period_end && ((rl_cnt_r & rl_mask) == rl_mask);

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rl_cnt_r <= 3'h0;
         rate_work_r <= 2'b00;
      end else if (!main_r.modulator_enable) begin
         rl_cnt_r <= 3'h0;
         rate_work_r <= aux_r.reload_rate;
      end else if (period_end) begin
         rl_cnt_r <= reload_evt ? 3'h0 : rl_cnt_r + 3'h1;
         rate_work_r <= aux_r.reload_rate;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pres_work_r <= 2'b00;
         period_work_r <= mpc_pkg::PERIOD_RST;
         for (int i = 0; i < mpc_pkg::NCH; i++) begin
            duty_work_r[i] <= mpc_pkg::DUTY_RST;
         end
      end else if (reload_evt && main_r.values_ready) begin
         pres_work_r <= aux_r.prescale;
         period_work_r <= period_hold_r;
         for (int i = 0; i < mpc_pkg::NCH; i++) begin
            duty_work_r[i] <= duty_hold_r[i];
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         mod_active_r <= 1'b0;
      end else if (!main_r.outputs_off_ctl) begin
         mod_active_r <= 1'b0;
      end else if (reload_evt) begin
         mod_active_r <= 1'b1;
      end
   end

   // ------------------------------------------------------------
   // compare, dead time, polarity and forcing
   // ------------------------------------------------------------
   always_comb begin
      for (int i = 0; i < mpc_pkg::NCH; i++) begin
         raw[i] = cnt_r < duty_work_r[i];
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         raw_prev_r <= 6'h00;
         for (int p = 0; p < 3; p++) begin
            dt_cnt_r[p] <= 8'h00;
         end
      end else begin
         raw_prev_r <= raw;
         for (int p = 0; p < 3; p++) begin
            if (raw[2*p] != raw_prev_r[2*p]) begin
               // the change cycle is the first blanked tick, so load one less
               dt_cnt_r[p] <= (dead_r == 8'h00) ? 8'h00 : dead_r - 8'h01;
            end else if (pwm_tick && dt_cnt_r[p] != 8'h00) begin
               dt_cnt_r[p] <= dt_cnt_r[p] - 8'h01;
            end
         end
      end
   end

   always_comb begin
      for (int p = 0; p < 3; p++) begin
         // the change cycle itself is blanked when dead time is non-zero, so no overlap leaks out
         blank[p] = (dt_cnt_r[p] != 8'h00) || ((raw[2*p] != raw_prev_r[2*p]) && dead_r != 8'h00);
         if (aux_r.independent_channels) begin
            logic_out[2*p] = raw[2*p];
            logic_out[2*p+1] = raw[2*p+1];
         end else begin
            logic_out[2*p] = raw[2*p] && !blank[p];
            logic_out[2*p+1] = !raw[2*p] && !blank[p];
         end
      end
      for (int i = 0; i < mpc_pkg::NCH; i++) begin
         force_off[i] = !main_r.modulator_enable || !main_r.outputs_off_ctl || !mod_active_r ||
                        (main_r.selective_disable_ctl && outdis_r[i]);
         off_pat[i] = inv[i/2];
         out_nxt[i] = (logic_out[i] && !force_off[i]) ^ inv[i/2];
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pwm_out_r <= 6'h00;
         adc_trig_r <= 1'b0;
      end else begin
         pwm_out_r <= out_nxt;
         adc_trig_r <= period_end && main_r.converter_trigger_enable;
      end
   end

   // ------------------------------------------------------------
   // checks
   // ------------------------------------------------------------
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);

   a_off_immediate: assert property (!main_r.outputs_off_ctl && $stable(aux_r) |=> pwm_out == $past(off_pat))
      else $error("outputs not off after output-off clear");
   a_resume_reload: assert property ($rose(mod_active_r) |-> $past(reload_evt))
      else $error("modulator control resumed outside reload");
   a_sel_disable: assert property (main_r.selective_disable_ctl && outdis_r[0] && $stable(aux_r)
                                   |=> pwm_out[0] == $past(aux_r.pair0_invert))
      else $error("disabled output not forced off");
   a_trig_gate: assert property (adc_trig |-> $past(main_r.converter_trigger_enable) && $past(period_end))
      else $error("converter trigger while disabled");
   a_load_ready: assert property (reload_evt && main_r.values_ready |=> period_work_r == $past(period_hold_r))
      else $error("working period not loaded");
   a_keep_unready: assert property (reload_evt && !main_r.values_ready |=> $stable(period_work_r))
      else $error("working period changed without ready");
   a_stop_count: assert property (!main_r.modulator_enable [*2] |-> cnt_r == 16'h0000 && !adc_trig)
      else $error("counter runs while disabled");
   a_dead_lock: assert property (wr_en && widx == mpc_pkg::IDX_DEAD && main_r.modulator_enable |=> $stable(dead_r))
      else $error("dead time written while enabled");
   a_rate_eight: assert property (reload_evt && rate_work_r == 2'b11 |-> rl_cnt_r == 3'h7)
      else $error("reload spacing wrong for rate eight");
   a_pair_gap: assert property (!aux_r.independent_channels && $stable(aux_r)
                                |=> !((pwm_out[0] ^ $past(inv[0])) && (pwm_out[1] ^ $past(inv[0]))))
      else $error("complementary pair both active");
   a_pair_blank: assert property (!aux_r.independent_channels && raw[0] != raw_prev_r[0] && dead_r != 8'h00
                                  |=> (pwm_out[1:0] ^ {2{$past(inv[0])}}) == 2'b00)
      else $error("complementary pair not blanked at switch");

   c_reload_load: cover property (reload_evt && main_r.values_ready);
   c_center_turn: cover property (main_r.align_center && $rose(dir_down_r));
   c_resume: cover property ($rose(mod_active_r));
endmodule
`default_nettype wire

// ==== bench/mpc_gate_drv.sv ====
`default_nettype none
// ------------------------------------------------------------
// gate driver stand-in on the pwm pins
// ------------------------------------------------------------
module mpc_gate_drv (
   input wire logic pclk,
   input wire logic [5:0] pwm_out,
   input wire logic pwm_oe_n,
   input wire logic [2:0] inv,
   output int shoot_cnt
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [5:0] act;
   initial shoot_cnt = 0;
   // a pin is asserted when it leaves its off level
   always_comb act = pwm_out ^ {inv[2], inv[2], inv[1], inv[1], inv[0], inv[0]};
   // both switches of one leg on at once would short the supply
   always @(posedge pclk) begin
      if (!pwm_oe_n && ((act[0] && act[1]) || (act[2] && act[3]) || (act[4] && act[5]))) begin
         shoot_cnt <= shoot_cnt + 1;
      end
   end
endmodule
`default_nettype wire

// ==== bench/motor_pwm_control_regs_tb.sv ====
`default_nettype none
module motor_pwm_control_regs_tb;
   timeunit 1ns;
   timeprecision 1ps;
   // reserved bits 4 and 2 stay zero in every main word
   localparam logic [7:0] RUN = 8'h8b;
   localparam logic [7:0] RUNN = 8'h89;
   logic pclk, presetn, psel, penable, pwrite, ext_clk, pready, pslverr, pwm_oe_n, adc_trig;
   logic [15:0] paddr;
   logic [31:0] pwdata, prdata;
   logic [5:0] pwm_out;
   logic [2:0] inv;
   int shoot_cnt, pe;
   int mismatches = 0;
   int check_count = 0;
   int cyc = 0;
   mpc_regs uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .external_pwm_clock_in(ext_clk), .pwm_out(pwm_out), .pwm_oe_n(pwm_oe_n), .adc_trig(adc_trig));
   mpc_gate_drv drv (.pclk(pclk), .pwm_out(pwm_out), .pwm_oe_n(pwm_oe_n), .inv(inv), .shoot_cnt(shoot_cnt));
   initial begin
      pclk = 1'b0;
      forever #25 pclk = ~pclk;
   end
   always @(posedge pclk) cyc <= cyc + 1;
   // pin toggles every seventh cycle; source select is internal except in the external clock check of t_presc
   always @(posedge pclk) if (cyc % 7 == 0) ext_clk <= ~ext_clk;
   // ------------------------------------------------------------
   // helpers
   // ------------------------------------------------------------
   task automatic print_verdict();
      $display("checks %0d mismatches %0d", check_count, mismatches);
      if (mismatches == 0 && check_count > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask
   task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      check_count++;
      if (seen !== exp) begin
         mismatches++;
         $display("unexpected %s: expected %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic apb(input logic w, input logic [11:0] idx, input logic [31:0] d, output logic [31:0] q,
                      output logic e);
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= {2'b00, idx, 2'b00};
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1) @(posedge pclk);
      q = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic wr(input logic [11:0] idx, input logic [15:0] d);
      logic [31:0] q;
      logic e;
      apb(1'b1, idx, {16'h0000, d}, q, e);
   endtask
   task automatic rd(input logic [11:0] idx, output logic [31:0] q);
      logic e;
      apb(1'b0, idx, 32'h0000_0000, q, e);
   endtask
   task automatic wait_rdy();
      logic [31:0] q;
      int n;
      n = 0;
      q = 32'h0000_0002;
      while (q[1] !== 1'b0 && n < 30000) begin
         rd(mpc_pkg::IDX_MAIN, q);
         n++;
      end
      chk("ready cleared", q[1], 1'b0);
   endtask
   task automatic meas(output int p);
      int n, c0;
      n = 0;
      @(posedge pclk);
      while (adc_trig !== 1'b1 && n < 2000) begin
         @(posedge pclk);
         n++;
      end
      c0 = cyc;
      n = 0;
      @(posedge pclk);
      while (adc_trig !== 1'b1 && n < 2000) begin
         @(posedge pclk);
         n++;
      end
      p = cyc - c0;
   endtask
   task automatic obs(input int n, output logic [5:0] ever, output logic [5:0] alw);
      ever = 6'h00;
      alw = 6'h3f;
      repeat (n) begin
         @(posedge pclk);
         ever = ever | pwm_out;
         alw = alw & pwm_out;
      end
   endtask
   // ------------------------------------------------------------
   // scenarios
   // ------------------------------------------------------------
   task automatic t_reset();
      logic [31:0] q, s;
      logic e;
      rd(mpc_pkg::IDX_MAIN, q);
      chk("main reset", q, 32'h0000_0000);
      rd(mpc_pkg::IDX_AUX, q);
      chk("aux reset", q, 32'h0000_0000);
      rd(mpc_pkg::IDX_DEAD, q);
      chk("dead reset", q, 32'h0000_0001);
      apb(1'b0, 12'h0f40, 32'h0000_0000, q, e);
      chk("unmapped error", e, 1'b1);
      chk("oe_n disabled", pwm_oe_n, 1'b1);
      chk("ready high", pready, 1'b1);
      rd(mpc_pkg::IDX_STATUS, q);
      rd(mpc_pkg::IDX_STATUS, s);
      chk("counter stopped", s[15:0], q[15:0]);
      wr(mpc_pkg::IDX_DEAD, 16'h0003);
      rd(mpc_pkg::IDX_DEAD, q);
      chk("dead write idle", q, 32'h0000_0003);
      wr(mpc_pkg::IDX_AUX, 16'h0020);
      rd(mpc_pkg::IDX_AUX, q);
      chk("indep write idle", q, 32'h0000_0020);
      wr(mpc_pkg::IDX_AUX, 16'h0000);
      $display("done reset");
   endtask
   task automatic t_start();
      logic [31:0] q;
      wr(mpc_pkg::IDX_PERIOD, 16'h000f);
      for (int i = 0; i < 6; i++) wr(mpc_pkg::IDX_DUTY0 + 12'(i), 16'h0006);
      wr(mpc_pkg::IDX_MAIN, RUN);
      wait_rdy();
      chk("oe_n enabled", pwm_oe_n, 1'b0);
      wr(mpc_pkg::IDX_DEAD, 16'h0007);
      rd(mpc_pkg::IDX_DEAD, q);
      chk("dead write refused", q, 32'h0000_0003);
      wr(mpc_pkg::IDX_AUX, 16'h0020);
      rd(mpc_pkg::IDX_AUX, q);
      chk("indep write refused", q, 32'h0000_0000);
      meas(pe);
      // edge mode counts 0 up to period minus one: 15 ticks
      chk("edge period", pe, 15);
      $display("done start");
   endtask
   task automatic t_rate();
      int c0, d;
      for (int k = 0; k < 4; k++) begin
         wr(mpc_pkg::IDX_AUX, 16'(k << 6));
         repeat (8 * pe + 4) @(posedge pclk);
         wr(mpc_pkg::IDX_MAIN, RUN);
         wait_rdy();
         c0 = cyc;
         wr(mpc_pkg::IDX_MAIN, RUN);
         wait_rdy();
         d = cyc - c0;
         chk("reload spacing", d > (pe << k) - 8 && d <= (pe << k) + 8, 1'b1);
      end
      wr(mpc_pkg::IDX_AUX, 16'h0000);
      repeat (8 * pe + 4) @(posedge pclk);
      $display("done rate");
   endtask
   task automatic t_ready();
      logic [5:0] ev, al;
      wr(mpc_pkg::IDX_DUTY0, 16'h0000);
      repeat (3 * pe) @(posedge pclk);
      obs(2 * pe, ev, al);
      chk("duty kept", ev[0], 1'b1);
      wr(mpc_pkg::IDX_MAIN, RUN);
      wait_rdy();
      repeat (2) @(posedge pclk);
      obs(2 * pe, ev, al);
      chk("duty loaded", ev[0], 1'b0);
      wr(mpc_pkg::IDX_DUTY0, 16'h0006);
      wr(mpc_pkg::IDX_MAIN, RUN);
      wait_rdy();
      $display("done ready");
   endtask
   task automatic t_presc();
      int p;
      wr(mpc_pkg::IDX_AUX, 16'h0001);
      meas(p);
      chk("prescale held", p, pe);
      wr(mpc_pkg::IDX_MAIN, RUN);
      wait_rdy();
      meas(p);
      meas(p);
      chk("prescale by 2", p, 2 * pe);
      wr(mpc_pkg::IDX_AUX, 16'h0000);
      wr(mpc_pkg::IDX_MAIN, RUN);
      wait_rdy();
      wr(mpc_pkg::IDX_MAIN, RUNN | 8'h20);
      meas(p);
      meas(p);
      chk("center longer", p > pe, 1'b1);
      wr(mpc_pkg::IDX_MAIN, RUNN);
      meas(p);
      // pin rises every 14 cycles, one tick each
      wr(mpc_pkg::IDX_CFG, 16'h0001);
      meas(p);
      meas(p);
      chk("external clock", p, 14 * pe);
      wr(mpc_pkg::IDX_CFG, 16'h0000);
      meas(p);
      $display("done prescale");
   endtask
   task automatic t_off();
      logic [5:0] ev, al;
      wr(mpc_pkg::IDX_MAIN, 16'h0009);
      // pins are registered: the forced level shows one edge later
      @(posedge pclk);
      obs(2 * pe, ev, al);
      chk("off now", ev, 6'h00);
      wr(mpc_pkg::IDX_AUX, 16'h0014);
      // model polarity follows the pins, not the register write
      @(posedge pclk);
      inv <= 3'b101;
      obs(pe, ev, al);
      chk("inverted off level", {ev, al}, {6'h33, 6'h33});
      wr(mpc_pkg::IDX_AUX, 16'h0000);
      @(posedge pclk);
      inv <= 3'b000;
      wr(mpc_pkg::IDX_MAIN, RUNN);
      obs(3 * pe, ev, al);
      chk("resume at reload", ev != 6'h00, 1'b1);
      wr(mpc_pkg::IDX_OUTDIS, 16'h0001);
      wr(mpc_pkg::IDX_MAIN, RUNN | 8'h40);
      @(posedge pclk);
      obs(2 * pe, ev, al);
      chk("selective off", {ev[0], ev[2]}, 2'b01);
      wr(mpc_pkg::IDX_MAIN, RUNN);
      obs(2 * pe, ev, al);
      chk("selective released", ev[0], 1'b1);
      $display("done off");
   endtask
   task automatic t_trig();
      int n;
      n = 0;
      wr(mpc_pkg::IDX_MAIN, 16'h0081);
      @(posedge pclk);
      repeat (3 * pe) begin
         @(posedge pclk);
         if (adc_trig !== 1'b0) n++;
      end
      chk("no trigger", n, 0);
      chk("no overlap", shoot_cnt, 0);
      wr(mpc_pkg::IDX_MAIN, 16'h0000);
      @(posedge pclk);
      @(posedge pclk);
      chk("disabled pins", {pwm_oe_n, pwm_out}, 7'h40);
      $display("done trigger");
   endtask
   initial begin
      presetn = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 16'h0000;
      pwdata = 32'h0000_0000;
      ext_clk = 1'b0;
      inv = 3'b000;
      repeat (5) @(posedge pclk);
      presetn <= 1'b1;
      t_reset();
      t_start();
      t_rate();
      t_ready();
      t_presc();
      t_off();
      t_trig();
      print_verdict();
   end
   // first period runs on the reset period of 65535 cycles
   initial begin
      repeat (95000) @(posedge pclk);
      mismatches++;
      print_verdict();
   end
endmodule
`default_nettype wire
